// ==== logic/temp_core_consts.svh ====
// Constants for the temperature conversion core
`ifndef TEMP_CORE_CONSTS_SVH
`define TEMP_CORE_CONSTS_SVH
`define CMD_START_CONVERSION 8'h44
`define CMD_READ_PAD 8'hBE
`define RESULT_RESET_VALUE 16'h0550
`define RES_SELECT_RESET 2'b11
`define CLK_FREQ_MHZ 100
`define CONV_MAX_12_MS 750
`define CONV_12_CYCLES (`CONV_MAX_12_MS * 1000 * `CLK_FREQ_MHZ)
`define SLOT_HOLD_US 15
`define SLOT_HOLD_CYCLES (`SLOT_HOLD_US * `CLK_FREQ_MHZ)
`define FIFO_DEPTH_WORDS 8
`define ALARM_LSB 4
`define ALARM_MSB 11
`define SIGN_LSB 11
`endif

// ==== logic/temp_core_pkg.sv ====
// Types shared by the temperature conversion core
package temp_core_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONVERT = 3'b010,
    ST_FINISH = 3'b100
  } conv_state_t;
  typedef logic [1:0] res_sel_t;
endpackage

// ==== logic/byte_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr_valid,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_wr_ready,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data,
  output logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("byte_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [$clog2(DEPTH+1)-1:0] count_r;
  logic do_wr;
  logic do_rd;

  assign o_wr_ready = (count_r != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign o_rd_valid = (count_r != '0);
  assign do_wr = i_wr_valid && o_wr_ready;
  assign do_rd = o_rd_valid && i_rd_ready;
  assign o_rd_data = mem_r[rd_ptr_r];
  assign o_count = count_r;

  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_r <= count_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ==== logic/temperature_conversion_core.sv ====
// Temperature conversion core: command decode, timed conversion, result register, bit output
`timescale 1ns/1ns
`include "temp_core_consts.svh"
module temperature_conversion_core
  import temp_core_pkg::*;
#(
  parameter int CONV_12_CYCLES = `CONV_12_CYCLES,
  parameter int SLOT_HOLD_CYCLES = `SLOT_HOLD_CYCLES,
  parameter int FIFO_DEPTH = `FIFO_DEPTH_WORDS,
  parameter logic [63:0] DEVICE_CODE = 64'h0123_4567_89AB_CDEF // Arbitrary value, set per device
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd,
  output logic o_cmd_ready,
  input wire logic [15:0] i_sensor_temp,
  input wire logic i_cfg_we,
  input wire logic i_resolution_select_high,
  input wire logic i_resolution_select_low,
  input wire logic [7:0] i_alarm_high,
  input wire logic [7:0] i_alarm_low,
  input wire logic i_read_slot,
  input wire logic i_dq,
  output logic o_dq,
  output logic o_dq_oe,
  output logic o_busy,
  output logic o_conv_done,
  output logic [15:0] o_temperature_result,
  output logic [1:0] o_resolution,
  output logic o_alarm,
  output logic [63:0] o_device_code
);
  localparam int CW = $clog2(CONV_12_CYCLES + 1);
  localparam int HW = $clog2(SLOT_HOLD_CYCLES + 1);
  generate
    if (CONV_12_CYCLES < 8 || SLOT_HOLD_CYCLES < 1) begin : g_bad_time
      $error("conversion time must allow division by 8 and slot hold must be nonzero");
    end
  endgenerate

  // Conversion length for a resolution: 12-bit time shifted down per missing bit
  function automatic logic [CW-1:0] conv_limit(input res_sel_t res);
    logic [CW-1:0] full;
    full = CONV_12_CYCLES[CW-1:0];
    conv_limit = full >> (2'd3 - res);
  endfunction

  // Clear bits that the chosen resolution leaves undefined
  function automatic logic [15:0] mask_result(input logic [15:0] raw, input res_sel_t res);
    logic [15:0] m;
    m = 16'hFFFF << (2'd3 - res);
    mask_result = {{5{raw[10]}}, raw[10:0]} & m;
  endfunction

  conv_state_t state_r;
  conv_state_t state_nxt;
  logic [CW-1:0] conv_cnt_r;
  res_sel_t res_r;
  logic [15:0] result_r;
  logic alarm_r;
  logic done_r;
  logic [63:0] code_r;
  logic start_conv;
  logic start_read;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_count;
  logic fifo_wr_valid;
  logic fifo_wr_ready;
  logic [7:0] fifo_wr_data;
  logic push_hi_r;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  logic [7:0] fifo_rd_data;
  logic [7:0] shift_r;
  logic [3:0] bits_left_r;
  logic [HW-1:0] hold_r;
  logic slot_taken;

  // --------------------------------------------------------------------------
  // Command acceptance
  // --------------------------------------------------------------------------
  // Read needs room for both bytes, so refuse until two slots are free
  assign o_cmd_ready = (state_r == ST_IDLE) && !push_hi_r &&
    (fifo_count <= FIFO_DEPTH[$clog2(FIFO_DEPTH+1)-1:0] - 2'd2);
  // While converting the master keeps the bus quiet, so nothing else is taken
  assign start_conv = i_cmd_valid && o_cmd_ready && (i_cmd == `CMD_START_CONVERSION);
  assign start_read = i_cmd_valid && o_cmd_ready && (i_cmd == `CMD_READ_PAD);

  // --------------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start_conv) begin
          state_nxt = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (conv_cnt_r >= conv_limit(res_r) - 1'b1) begin
          state_nxt = ST_FINISH;
        end
      end
      ST_FINISH: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      conv_cnt_r <= '0;
    end else if (state_r == ST_CONVERT) begin
      conv_cnt_r <= conv_cnt_r + 1'b1;
    end else begin
      conv_cnt_r <= '0;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration, result and alarm
  // --------------------------------------------------------------------------
  // Resolution changes only between conversions, keeping the time base steady
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      res_r <= `RES_SELECT_RESET;
    end else if (i_cfg_we && state_r == ST_IDLE) begin
      res_r <= {i_resolution_select_high, i_resolution_select_low};
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      result_r <= `RESULT_RESET_VALUE;
    end else if (state_r == ST_FINISH) begin
      result_r <= mask_result(i_sensor_temp, res_r);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      alarm_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= (state_r == ST_FINISH);
      if (done_r) begin
        alarm_r <= ($signed(result_r[`ALARM_MSB:`ALARM_LSB]) > $signed(i_alarm_high)) ||
          ($signed(result_r[`ALARM_MSB:`ALARM_LSB]) < $signed(i_alarm_low));
      end
    end
  end

  // Fixed code, so no reset term; unknown only until the first edge
  always_ff @(posedge i_clk) begin
    code_r <= DEVICE_CODE;
  end

  assign o_busy = (state_r != ST_IDLE);
  assign o_conv_done = done_r;
  assign o_temperature_result = result_r;
  assign o_resolution = res_r;
  assign o_alarm = alarm_r;
  assign o_device_code = code_r;

  // --------------------------------------------------------------------------
  // Read path: result bytes through the FIFO to the pin
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      push_hi_r <= 1'b0;
    end else if (start_read) begin
      push_hi_r <= 1'b1;
    end else if (fifo_wr_ready) begin
      push_hi_r <= 1'b0;
    end
  end

  assign fifo_wr_valid = start_read || push_hi_r;
  assign fifo_wr_data = push_hi_r ? result_r[15:8] : result_r[7:0];

  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr_valid(fifo_wr_valid),
    .i_wr_data(fifo_wr_data),
    .o_wr_ready(fifo_wr_ready),
    .o_rd_valid(fifo_rd_valid),
    .i_rd_ready(fifo_rd_ready),
    .o_rd_data(fifo_rd_data),
    .o_count(fifo_count)
  );

  // A slot starts when the master pulls low; idle slots stall the FIFO
  assign slot_taken = i_read_slot && !i_dq && (hold_r == '0) && (bits_left_r != 4'd0);
  assign fifo_rd_ready = (bits_left_r == 4'd0);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shift_r <= 8'h00;
      bits_left_r <= 4'd0;
    end else if (fifo_rd_valid && fifo_rd_ready) begin
      shift_r <= fifo_rd_data;
      bits_left_r <= 4'd8;
    end else if (slot_taken) begin
      shift_r <= {1'b0, shift_r[7:1]};
      bits_left_r <= bits_left_r - 4'd1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hold_r <= '0;
    end else if (slot_taken && !shift_r[0]) begin
      hold_r <= SLOT_HOLD_CYCLES[HW-1:0];
    end else if (hold_r != '0) begin
      hold_r <= hold_r - 1'b1;
    end
  end

  // Open drain: the line is only ever pulled low or released
  assign o_dq = 1'b0;
  assign o_dq_oe = (hold_r != '0);

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_idle_until_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == ST_IDLE && !start_conv) |=> state_r == ST_IDLE)
    else $error("left idle without a start command");
  a_result_update_time: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (result_r != $past(result_r)) |-> ($past(state_r) == ST_FINISH) && state_r == ST_IDLE)
    else $error("result changed outside the finish step");
  a_low_bits_masked: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == ST_FINISH && res_r == 2'b00) |=> result_r[2:0] == 3'b000)
    else $error("undefined bits not cleared at nine bits");
  a_sign_bits_equal: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == ST_FINISH) |=> (result_r[15:`SIGN_LSB] == {5{result_r[10]}}))
    else $error("sign bits not extended");
  a_conv_time_bound: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r == ST_CONVERT) |-> conv_cnt_r < conv_limit(res_r))
    else $error("conversion ran past its limit");
  a_res_steady_busy: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state_r != ST_IDLE) |=> $stable(res_r))
    else $error("resolution changed during conversion");
  a_alarm_after_done: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    done_r |=> alarm_r == (($signed(result_r[11:4]) > $signed($past(i_alarm_high))) ||
      ($signed(result_r[11:4]) < $signed($past(i_alarm_low)))))
    else $error("alarm flag not updated after conversion");
  a_read_low_first: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    start_read |-> fifo_wr_data == result_r[7:0] ##1 (push_hi_r && fifo_wr_data == result_r[15:8]))
    else $error("result bytes pushed out of order");
  a_pin_drive_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (slot_taken && !shift_r[0]) |=> (o_dq_oe && !o_dq))
    else $error("zero bit not pulled low");
endmodule

// ==== test/bus_master_model.sv ====
// Behavioural bus master: read slots, weak and strong pullup
`timescale 1ns/1ns
module bus_master_model #(
  parameter int HOLD = 4
) (
  input wire logic i_clk,
  input wire logic i_dev_oe,
  input wire logic i_busy,
  input wire logic i_get,
  output logic o_read_slot,
  output logic o_wire,
  output logic o_bit_valid,
  output logic o_bit
);
  logic pull_low = 1'b0;
  logic strong_pullup;
  // Strong pullup held for the whole conversion
  assign strong_pullup = i_busy;
  // Weak pullup sets the level once nobody pulls low
  assign o_wire = strong_pullup | !(pull_low | i_dev_oe);
  initial begin
    o_read_slot = 1'b0;
    o_bit_valid = 1'b0;
    o_bit = 1'b0;
    forever begin
      @(posedge i_clk);
      if (i_get === 1'b1 && i_busy === 1'b0) begin
        o_read_slot <= 1'b1;
        pull_low <= 1'b1;
        @(posedge i_clk);
        o_read_slot <= 1'b0;
        pull_low <= 1'b0;
        repeat (2) @(posedge i_clk);
        o_bit <= o_wire;
        o_bit_valid <= 1'b1;
        @(posedge i_clk);
        o_bit_valid <= 1'b0;
        // Recovery so the device hold time has run out
        repeat (HOLD + 1) @(posedge i_clk);
      end
    end
  end
endmodule

// ==== test/tb_temperature_conversion_core.sv ====
// Self-checking bench for the temperature conversion core
`timescale 1ns/1ns
module tb_temperature_conversion_core;
  localparam int CONV = 64;
  localparam int HOLD = 4;
  localparam logic [63:0] CODE = 64'h5a5a_0f0f_3c3c_9696; // Arbitrary value
  logic [63:0] dev_code;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_cmd_valid = 1'b0;
  logic [7:0] i_cmd = 8'h00;
  logic [15:0] i_sensor_temp = 16'h0000;
  logic i_cfg_we = 1'b0;
  logic [1:0] res_code = 2'b11;
  logic [7:0] alarm_hi = 8'h7f;
  logic [7:0] alarm_lo = 8'h80;
  logic get_bits = 1'b0;
  logic read_slot, dq_wire, bit_valid, bit_val, o_cmd_ready, o_dq, o_dq_oe, o_busy, o_conv_done, o_alarm;
  logic [15:0] o_temperature_result;
  logic [1:0] o_resolution;
  logic [15:0] last_exp;
  logic [15:0] exp_res_q[$];
  int exp_cyc_q[$];
  logic exp_alarm_q[$];
  logic exp_bit_q[$];
  logic alarm_due = 1'b0;
  logic [15:0] sensors[4] = '{16'h0191, 16'hfe6f, 16'h00a2, 16'hff5e};
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int t;

  temperature_conversion_core #(.CONV_12_CYCLES(CONV), .SLOT_HOLD_CYCLES(HOLD), .DEVICE_CODE(CODE)) dut_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .o_cmd_ready(o_cmd_ready), .i_sensor_temp(i_sensor_temp), .i_cfg_we(i_cfg_we),
    .i_resolution_select_high(res_code[1]), .i_resolution_select_low(res_code[0]),
    .i_alarm_high(alarm_hi), .i_alarm_low(alarm_lo), .i_read_slot(read_slot), .i_dq(dq_wire),
    .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_busy(o_busy), .o_conv_done(o_conv_done),
    .o_temperature_result(o_temperature_result), .o_resolution(o_resolution), .o_alarm(o_alarm),
    .o_device_code(dev_code));
  bus_master_model #(.HOLD(HOLD)) master_u (
    .i_clk(i_clk), .i_dev_oe(o_dq_oe), .i_busy(o_busy), .i_get(get_bits),
    .o_read_slot(read_slot), .o_wire(dq_wire), .o_bit_valid(bit_valid), .o_bit(bit_val));

  always #5 i_clk = ~i_clk;
  // Ceiling well above nine conversions and one read
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic cmp_val(input string name, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmp_bit(input string name, input logic exp, input logic got);
    cmp_val(name, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic report_and_stop();
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Returns cyc as it stands in the cycle that ends at the taking edge
  task automatic send_cmd(input logic [7:0] c, output int tk);
    int n;
    n = 0;
    @(posedge i_clk);
    i_cmd_valid <= 1'b1;
    i_cmd <= c;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_cmd_ready !== 1'b1 && n < 200);
    cmp_bit("cmd_ready", 1'b1, o_cmd_ready);
    @(posedge i_clk);
    tk = cyc;
    i_cmd_valid <= 1'b0;
  endtask
  task automatic convert(input logic [1:0] r, input logic [15:0] s);
    logic [7:0] hi, lo;
    logic signed [7:0] v;
    int n;
    hi = 8'($urandom);
    lo = 8'($urandom);
    @(posedge i_clk);
    i_cfg_we <= 1'b1;
    res_code <= r;
    alarm_hi <= hi;
    alarm_lo <= lo;
    i_sensor_temp <= s;
    @(posedge i_clk);
    i_cfg_we <= 1'b0;
    @(negedge i_clk);
    cmp_val("resolution", {14'h0000, r}, {14'h0000, o_resolution});
    last_exp = {{5{s[10]}}, s[10:0]} & (16'hffff << (3 - r));
    v = last_exp[11:4];
    exp_res_q.push_back(last_exp);
    exp_alarm_q.push_back(v > $signed(hi) || v < $signed(lo));
    send_cmd(8'h44, t);
    exp_cyc_q.push_back(t + (CONV >> (3 - r)) + 2);
    // Busy: new command refused, resolution write dropped
    @(posedge i_clk);
    i_cfg_we <= 1'b1;
    res_code <= ~r;
    @(posedge i_clk);
    i_cfg_we <= 1'b0;
    @(negedge i_clk);
    cmp_bit("busy", 1'b1, o_busy);
    cmp_bit("ready_busy", 1'b0, o_cmd_ready);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_busy !== 1'b0 && n < 300);
    cmp_bit("busy_end", 1'b0, o_busy);
    cmp_val("res_kept", {14'h0000, r}, {14'h0000, o_resolution});
  endtask

  // --------------------------------------------------
  // Monitor
  // --------------------------------------------------
  always @(negedge i_clk) begin
    if (alarm_due) begin
      cmp_bit("alarm", exp_alarm_q.pop_front(), o_alarm);
    end
    alarm_due = (o_conv_done === 1'b1);
    if (o_conv_done === 1'b1) begin
      cmp_val("result", exp_res_q.pop_front(), o_temperature_result);
      cmp_val("done_cycle", 16'(exp_cyc_q.pop_front()), 16'(cyc));
    end
    if (bit_valid === 1'b1) begin
      cmp_bit("read_bit", exp_bit_q.pop_front(), bit_val);
    end
    if (o_dq_oe === 1'b1) begin
      cmp_bit("dq_low", 1'b0, o_dq);
    end
  end

  initial begin
    int n;
    void'($urandom(32'h2bfb_051a));
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    cmp_val("reset_result", 16'h0550, o_temperature_result);
    cmp_val("reset_res", 16'h0003, {14'h0000, o_resolution});
    cmp_val("device_code", CODE, dev_code);
    send_cmd(8'h48, t);
    repeat (3) @(negedge i_clk);
    cmp_bit("idle", 1'b0, o_busy);
    for (int i = 0; i < 8; i++) begin
      convert(2'(i), (i < 4) ? sensors[i] : 16'($urandom));
    end
    convert(2'b11, sensors[1]);
    send_cmd(8'hbe, t);
    for (int i = 0; i < 16; i++) begin
      exp_bit_q.push_back(last_exp[i]);
    end
    repeat (3) @(posedge i_clk);
    get_bits <= 1'b1;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (exp_bit_q.size() > 0 && n < 1000);
    @(posedge i_clk);
    get_bits <= 1'b0;
    cmp_val("bits_left", 16'h0000, 16'(exp_bit_q.size()));
    report_and_stop();
  end
endmodule
